// >>> hw/qsr_pkg.sv
// questionable status reporting: constants, types, command codes
// assumes one 20 MHz clock and a synchronous active-high reset
//
// What this block does
// - operation event read always returns zero
// - operation mask takes 0..255, reads zero
// - condition register read-only, live protection status
// - event register holds only filtered transitions
// - summary bit set when enabled and events
// - enable mask selects events driving summary
// - falling filter bit catches 1-to-0 changes
// - rising filter bit catches 0-to-1 changes
// - both filter bits zero: never set
// - bits 8..4: overvoltage, line, current, fan, short
// - bits 3..0: temperature, power, dc-dc, ac-dc
// - falling filter 16 bits, rising 9 bits
// - remote inhibit low suppresses output
// - output indicator high while delivering output
// - fault output low in any protection state
package qsr_pkg;

    // ----------------------------------------
    // widths and reset values
    // ----------------------------------------
    localparam int          QSR_CW       = 9;
    localparam int          QSR_RW       = 16;
    localparam int          QSR_OPW      = 8;
    localparam logic [15:0] QSR_EN_RST   = 16'h0000;
    localparam logic [15:0] QSR_FALL_RST = 16'h0000;
    localparam logic [8:0]  QSR_RISE_RST = 9'h000;
    localparam logic [7:0]  QSR_OPEN_RST = 8'h00;
    localparam logic [8:0]  QSR_VEC_RST  = 9'h000;
    localparam logic [15:0] QSR_ZERO     = 16'h0000;

    // ----------------------------------------
    // protection condition vector
    // ----------------------------------------
    // msb first: bit 8 down to bit 0
    typedef struct packed {
        logic output_overvoltage_flag;
        logic line_input_fault_flag;
        logic overcurrent_flag;
        logic fan_failure_flag;
        logic output_short_flag;
        logic over_temperature_flag;
        logic overpower_flag;
        logic inner_dcdc_stage_fault;
        logic inner_acdc_stage_fault;
    } qsr_prot_t;

    // ----------------------------------------
    // status command port
    // ----------------------------------------
    typedef enum logic [2:0] {
        QSR_SEL_OP_EVENT,
        QSR_SEL_OP_ENABLE,
        QSR_SEL_Q_COND,
        QSR_SEL_Q_EVENT,
        QSR_SEL_Q_ENABLE,
        QSR_SEL_Q_FALL,
        QSR_SEL_Q_RISE,
        QSR_SEL_CLEAR
    } qsr_sel_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        qsr_sel_t    sel;
        logic [15:0] data;
    } qsr_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } qsr_rsp_t;

endpackage

// >>> hw/qsr_top.sv
// questionable status reporting: registers, filters, summary, pins
// assumes command requests and pins synchronous to mclk_i
`timescale 1ns/1ps

module qsr_top
    import qsr_pkg::*;
(
    input  wire logic      mclk_i,
    input  wire logic      srst_i,
    input  wire qsr_cmd_t  cmd_i,
    output qsr_rsp_t       rsp_o,
    input  wire qsr_prot_t prot_i,
    input  wire logic      srq_questionable_summary_bit_en_i,
    input  wire logic      output_request_i,
    input  wire logic      remote_inhibit_n_i,
    output logic           questionable_summary_bit_summary_o,
    output logic           output_enable_o,
    output logic           output_active_indicator_o,
    output logic           fault_out_n_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [8:0]  cond_r;
    logic [8:0]  cond_nxt;
    logic [8:0]  event_r;
    logic [8:0]  event_nxt;
    logic [15:0] enable_r;
    logic [15:0] enable_nxt;
    logic [15:0] fall_r;
    logic [15:0] fall_nxt;
    logic [8:0]  rise_r;
    logic [8:0]  rise_nxt;
    logic [7:0]  op_en_r;
    logic [7:0]  op_en_nxt;
    qsr_rsp_t    rsp_r;
    qsr_rsp_t    rsp_nxt;
    logic        summary_r;
    logic        summary_nxt;
    logic        out_en_r;
    logic        out_en_nxt;
    logic        active_r;
    logic        active_nxt;
    logic        fault_n_r;
    logic        fault_n_nxt;

    logic [8:0]  prot_v;
    logic [8:0]  set_v;
    logic        rd_req;
    logic        wr_req;
    logic        ev_read;
    logic        clr_req;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] widen9(input logic [8:0] v);
        widen9 = {7'h00, v};
    endfunction

    function automatic logic is_cmd(input qsr_cmd_t c,
                                    input logic     wr,
                                    input qsr_sel_t s);
        is_cmd = c.valid && (c.write == wr) && (c.sel == s);
    endfunction

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    assign prot_v  = prot_i;
    assign rd_req  = cmd_i.valid && !cmd_i.write;
    assign wr_req  = cmd_i.valid && cmd_i.write;
    assign ev_read = is_cmd(cmd_i, 1'b0, QSR_SEL_Q_EVENT);
    assign clr_req = is_cmd(cmd_i, 1'b1, QSR_SEL_CLEAR);

    // ----------------------------------------
    // transition filters and event latch
    // ----------------------------------------
    always_comb begin
        // compare live vector against last clock's copy
        cond_nxt = prot_v;
        set_v    = (rise_r & prot_v & ~cond_r)
                 | (fall_r[8:0] & ~prot_v & cond_r);
        event_nxt = event_r;
        if (ev_read || clr_req) begin
            event_nxt = 9'h000;
        end
        event_nxt = event_nxt | set_v;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cond_r  <= QSR_VEC_RST;
            event_r <= QSR_VEC_RST;
        end else begin
            cond_r  <= cond_nxt;
            event_r <= event_nxt;
        end
    end

    // ----------------------------------------
    // writable masks and filters
    // ----------------------------------------
    always_comb begin
        enable_nxt = enable_r;
        fall_nxt   = fall_r;
        rise_nxt   = rise_r;
        op_en_nxt  = op_en_r;
        if (wr_req) begin
            if (cmd_i.sel == QSR_SEL_Q_ENABLE) begin
                enable_nxt = cmd_i.data;
            end else if (cmd_i.sel == QSR_SEL_Q_FALL) begin
                fall_nxt = cmd_i.data;
            end else if (cmd_i.sel == QSR_SEL_Q_RISE) begin
                rise_nxt = cmd_i.data[8:0];
            end else if (cmd_i.sel == QSR_SEL_OP_ENABLE) begin
                op_en_nxt = cmd_i.data[7:0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            enable_r <= QSR_EN_RST;
            fall_r   <= QSR_FALL_RST;
            rise_r   <= QSR_RISE_RST;
            op_en_r  <= QSR_OPEN_RST;
        end else begin
            enable_r <= enable_nxt;
            fall_r   <= fall_nxt;
            rise_r   <= rise_nxt;
            op_en_r  <= op_en_nxt;
        end
    end

    // ----------------------------------------
    // read answers
    // ----------------------------------------
    always_comb begin
        rsp_nxt.valid = rd_req;
        rsp_nxt.data  = QSR_ZERO;
        if (rd_req) begin
            if (cmd_i.sel == QSR_SEL_OP_EVENT) begin
                rsp_nxt.data = QSR_ZERO;
            end else if (cmd_i.sel == QSR_SEL_OP_ENABLE) begin
                rsp_nxt.data = QSR_ZERO;
            end else if (cmd_i.sel == QSR_SEL_Q_COND) begin
                rsp_nxt.data = widen9(cond_r);
            end else if (cmd_i.sel == QSR_SEL_Q_EVENT) begin
                rsp_nxt.data = widen9(event_r);
            end else if (cmd_i.sel == QSR_SEL_Q_ENABLE) begin
                rsp_nxt.data = enable_r;
            end else if (cmd_i.sel == QSR_SEL_Q_FALL) begin
                rsp_nxt.data = fall_r;
            end else if (cmd_i.sel == QSR_SEL_Q_RISE) begin
                rsp_nxt.data = widen9(rise_r);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    // ----------------------------------------
    // summary bit and pins
    // ----------------------------------------
    always_comb begin
        summary_nxt = srq_questionable_summary_bit_en_i
                    && ((event_r & enable_r[8:0]) != 9'h000);
        fault_n_nxt = (prot_v == 9'h000);
        out_en_nxt  = output_request_i && remote_inhibit_n_i;
        active_nxt  = out_en_r;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            summary_r <= 1'b0;
            fault_n_r <= 1'b1;
            out_en_r  <= 1'b0;
            active_r  <= 1'b0;
        end else begin
            summary_r <= summary_nxt;
            fault_n_r <= fault_n_nxt;
            out_en_r  <= out_en_nxt;
            active_r  <= active_nxt;
        end
    end

    assign rsp_o                     = rsp_r;
    assign questionable_summary_bit_summary_o            = summary_r;
    assign output_enable_o           = out_en_r;
    assign output_active_indicator_o = active_r;
    assign fault_out_n_o             = fault_n_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_rd(qsr_sel_t s);
        cmd_i.valid && !cmd_i.write && cmd_i.sel == s;
    endsequence

    sequence s_wr(qsr_sel_t s);
        cmd_i.valid && cmd_i.write && cmd_i.sel == s;
    endsequence

    a_op_event_zero: assert property (
        s_rd(QSR_SEL_OP_EVENT) |=> rsp_o.valid && rsp_o.data == 16'h0000)
        else $error("operation event read not zero");

    a_op_mask_zero: assert property (
        s_rd(QSR_SEL_OP_ENABLE) ##0 op_en_r != 8'h00
        |=> rsp_o.valid && rsp_o.data == 16'h0000)
        else $error("operation mask read not zero");

    a_op_mask_store: assert property (
        s_wr(QSR_SEL_OP_ENABLE) |=> op_en_r == $past(cmd_i.data[7:0]))
        else $error("operation mask write not stored");

    a_cond_live: assert property (
        s_rd(QSR_SEL_Q_COND) |=> rsp_o.data == {7'h00, $past(prot_i, 2)})
        else $error("condition read does not follow inputs");

    a_event_read: assert property (
        s_rd(QSR_SEL_Q_EVENT) |=> rsp_o.data == {7'h00, $past(event_r)})
        else $error("event read value wrong");

    a_event_clear: assert property (
        (s_rd(QSR_SEL_Q_EVENT) or s_wr(QSR_SEL_CLEAR)) ##0 set_v == 9'h000
        |=> event_r == 9'h000)
        else $error("event not cleared by read or clear");

    a_event_sticky: assert property (
        !ev_read && !clr_req |=> (event_r & $past(event_r)) == $past(event_r))
        else $error("event bit lost without read");

    a_summary_out: assert property (
        srq_questionable_summary_bit_en_i && (event_r & enable_r[8:0]) != 9'h000 |=> questionable_summary_bit_summary_o)
        else $error("summary bit not set");

    a_summary_mask: assert property (
        (event_r & enable_r[8:0]) == 9'h000 |=> !questionable_summary_bit_summary_o)
        else $error("summary bit set by masked event");

    a_rise_sets: assert property (
        (rise_r & prot_v & ~cond_r) != 9'h000
        |=> (event_r & $past(rise_r & prot_v & ~cond_r))
            == $past(rise_r & prot_v & ~cond_r))
        else $error("rising change missed");

    a_fall_sets: assert property (
        (fall_r[8:0] & ~prot_v & cond_r) != 9'h000
        |=> (event_r & $past(fall_r[8:0] & ~prot_v & cond_r))
            == $past(fall_r[8:0] & ~prot_v & cond_r))
        else $error("falling change missed");

    a_no_filter: assert property (
        1'b1 |=> (event_r & ~$past(event_r)
                  & ~$past(rise_r | fall_r[8:0])) == 9'h000)
        else $error("unfiltered bit set event");

    a_inhibit_out: assert property (
        !remote_inhibit_n_i |=> !output_enable_o ##1 !output_active_indicator_o)
        else $error("output not suppressed by inhibit");

    a_fault_pin: assert property (
        prot_v != 9'h000 |=> !fault_out_n_o)
        else $error("fault output not low in protection");

    a_fault_idle: assert property (
        prot_v == 9'h000 |=> fault_out_n_o)
        else $error("fault output low without protection");

    a_indicator_on: assert property (
        output_enable_o |=> output_active_indicator_o)
        else $error("indicator low while output delivered");

    a_indicator_off: assert property (
        !output_enable_o |=> !output_active_indicator_o)
        else $error("indicator high after output stopped");

    a_output_on: assert property (
        output_request_i && remote_inhibit_n_i |=> output_enable_o)
        else $error("output not enabled on request");

    a_cond_copy: assert property (
        1'b1 |=> cond_r == $past(prot_v))
        else $error("condition copy not last clock vector");

    a_enable_write: assert property (
        s_wr(QSR_SEL_Q_ENABLE) |=> enable_r == $past(cmd_i.data))
        else $error("enable mask write not stored");

    a_fall_write: assert property (
        s_wr(QSR_SEL_Q_FALL) |=> fall_r == $past(cmd_i.data))
        else $error("falling filter write not stored");

    a_rise_write: assert property (
        s_wr(QSR_SEL_Q_RISE) |=> rise_r == $past(cmd_i.data[8:0]))
        else $error("rising filter write not stored");

endmodule

// >>> testbench/qsr_top_test.sv
// testbench for qsr_top: status commands, filters, summary bit, pins
// assumes qsr_pkg and qsr_top are compiled before this file
`timescale 1ns/1ps

module qsr_top_test;
    import qsr_pkg::*;

    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic      mclk_i    = 1'b0;
    logic      srst_i    = 1'b1;
    qsr_cmd_t  cmd       = '0;
    qsr_rsp_t  rsp;
    qsr_prot_t prot      = '0;
    logic      srq       = 1'b0;
    logic      oreq      = 1'b0;
    logic      inh_n     = 1'b1;
    logic      summ;
    logic      oen;
    logic      oind;
    logic      flt_n;
    int        error_cnt = 0;
    int        checks    = 0;

    always #25 mclk_i = ~mclk_i;

    qsr_top qsr_top_inst (
        .mclk_i                    (mclk_i),
        .srst_i                    (srst_i),
        .cmd_i                     (cmd),
        .rsp_o                     (rsp),
        .prot_i                    (prot),
        .srq_questionable_summary_bit_en_i             (srq),
        .output_request_i          (oreq),
        .remote_inhibit_n_i        (inh_n),
        .questionable_summary_bit_summary_o            (summ),
        .output_enable_o           (oen),
        .output_active_indicator_o (oind),
        .fault_out_n_o             (flt_n)
    );

    // ----------------------------------------
    // compare, drive and report tasks
    // ----------------------------------------
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask

    task automatic settle;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    task automatic issue(input logic w, input qsr_sel_t s, input logic [15:0] d);
        @(posedge mclk_i);
        cmd <= '{valid: 1'b1, write: w, sel: s, data: d};
        @(posedge mclk_i);
        cmd <= '0;
        #1;
    endtask

    task automatic wr(input qsr_sel_t s, input logic [15:0] d);
        issue(1'b1, s, d);
    endtask

    task automatic rd(input qsr_sel_t s, input logic [15:0] exp, input string msg);
        issue(1'b0, s, 16'h0000);
        check_bit(rsp.valid, 1'b1, msg);
        check_word(rsp.data, exp, msg);
        @(posedge mclk_i);
        #1;
        check_bit(rsp.valid, 1'b0, msg);
        check_word(rsp.data, 16'h0000, msg);
    endtask

    task automatic set_prot(input qsr_prot_t p);
        @(posedge mclk_i);
        prot <= p;
        settle();
    endtask

    task automatic step(input logic s, input logic r, input logic n);
        @(posedge mclk_i);
        srq   <= s;
        oreq  <= r;
        inh_n <= n;
        settle();
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        check_bit(flt_n, 1'b1, "fault idle");
        check_bit(oen, 1'b0, "enable idle");
        check_bit(summ, 1'b0, "summary idle");
        rd(QSR_SEL_Q_COND, QSR_ZERO, "cond reset");
        rd(QSR_SEL_Q_ENABLE, QSR_EN_RST, "enable reset");
        rd(QSR_SEL_Q_FALL, QSR_FALL_RST, "fall reset");
        rd(QSR_SEL_Q_RISE, {7'h00, QSR_RISE_RST}, "rise reset");
    endtask

    task automatic t_op_regs;
        wr(QSR_SEL_OP_ENABLE, 16'h00ff);
        rd(QSR_SEL_OP_ENABLE, 16'h0000, "op mask");
        wr(QSR_SEL_OP_EVENT, 16'hffff);
        rd(QSR_SEL_OP_EVENT, 16'h0000, "op event");
    endtask

    task automatic t_masks;
        wr(QSR_SEL_Q_ENABLE, 16'hffff);
        rd(QSR_SEL_Q_ENABLE, 16'hffff, "enable rw");
        wr(QSR_SEL_Q_FALL, 16'ha5c3);
        rd(QSR_SEL_Q_FALL, 16'ha5c3, "fall rw");
        wr(QSR_SEL_Q_RISE, 16'hffff);
        rd(QSR_SEL_Q_RISE, 16'h01ff, "rise rw");
        wr(QSR_SEL_Q_FALL, 16'h0000);
        wr(QSR_SEL_Q_RISE, 16'h0000);
    endtask

    task automatic t_cond_map;
        qsr_prot_t p;
        for (int i = 0; i < 9; i++) begin
            p = '0;
            case (i)
                0: p.inner_acdc_stage_fault = 1'b1;
                1: p.inner_dcdc_stage_fault = 1'b1;
                2: p.overpower_flag = 1'b1;
                3: p.over_temperature_flag = 1'b1;
                4: p.output_short_flag = 1'b1;
                5: p.fan_failure_flag = 1'b1;
                6: p.overcurrent_flag = 1'b1;
                7: p.line_input_fault_flag = 1'b1;
                default: p.output_overvoltage_flag = 1'b1;
            endcase
            set_prot(p);
            rd(QSR_SEL_Q_COND, 16'h0001 << i, "bit map");
            check_bit(flt_n, 1'b0, "fault active");
        end
        set_prot('0);
        check_bit(flt_n, 1'b1, "fault gone");
        wr(QSR_SEL_Q_COND, 16'hffff);
        wr(QSR_SEL_Q_EVENT, 16'hffff);
        rd(QSR_SEL_Q_COND, 16'h0000, "cond read only");
        rd(QSR_SEL_Q_EVENT, 16'h0000, "no filter");
    endtask

    task automatic t_filters;
        wr(QSR_SEL_Q_RISE, 16'h000a);
        wr(QSR_SEL_Q_FALL, 16'h0005);
        set_prot(9'h00f);
        rd(QSR_SEL_Q_EVENT, 16'h000a, "rising events");
        rd(QSR_SEL_Q_EVENT, 16'h0000, "read clears");
        set_prot('0);
    endtask

    task automatic t_summary;
        step(1'b1, 1'b0, 1'b1);
        wr(QSR_SEL_Q_ENABLE, 16'h000a);
        settle();
        check_bit(summ, 1'b0, "masked event");
        wr(QSR_SEL_Q_ENABLE, 16'h0004);
        settle();
        check_bit(summ, 1'b1, "enabled event");
        step(1'b0, 1'b0, 1'b1);
        check_bit(summ, 1'b0, "service bit off");
        step(1'b1, 1'b0, 1'b1);
        check_bit(summ, 1'b1, "service bit on");
        rd(QSR_SEL_Q_EVENT, 16'h0005, "falling events");
        settle();
        check_bit(summ, 1'b0, "summary after read");
        set_prot(9'h002);
        wr(QSR_SEL_CLEAR, 16'h0000);
        rd(QSR_SEL_Q_EVENT, 16'h0000, "clear status");
        set_prot('0);
        rd(QSR_SEL_Q_EVENT, 16'h0000, "fall not enabled");
    endtask

    task automatic t_pins;
        step(1'b0, 1'b1, 1'b1);
        check_bit(oen, 1'b1, "output on");
        check_bit(oind, 1'b1, "indicator on");
        step(1'b0, 1'b1, 1'b0);
        check_bit(oen, 1'b0, "inhibited");
        check_bit(oind, 1'b0, "indicator off");
        step(1'b0, 1'b0, 1'b1);
        check_bit(oind, 1'b0, "no request");
        check_bit(oen, 1'b0, "no request enable");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        t_reset();
        t_op_regs();
        t_masks();
        t_cond_map();
        t_filters();
        t_summary();
        t_pins();
        results();
    end

    initial begin
        repeat (2000) @(posedge mclk_i);
        error_cnt++;
        results();
    end
endmodule
